// *** gpc_pkg.sv ***
/*
 Package for the eight-bit port control block: register offsets,
 sub-register select codes, reset values and the carrier structs.
 Assumes a byte-wide register port with 12-bit addresses.
*/
package gpc_pkg;

   localparam int PORT_W = 8;
   localparam int ADDR_W = 12;

   // Directly addressed registers
   localparam logic [ADDR_W-1:0] OFF_SUBREG_SELECT = 12'h0fd0;
   localparam logic [ADDR_W-1:0] OFF_SUBREG_WINDOW = 12'h0fd1;
   localparam logic [ADDR_W-1:0] OFF_INPUT_SAMPLE  = 12'h0fd2;
   localparam logic [ADDR_W-1:0] OFF_OUTPUT_VALUE  = 12'h0fd3;

   // Sub-register select codes reached through the window
   localparam logic [7:0] SEL_DIRECTION   = 8'h01;
   localparam logic [7:0] SEL_PERIPHERAL  = 8'h02;
   localparam logic [7:0] SEL_OPEN_DRAIN  = 8'h03;
   localparam logic [7:0] SEL_HIGH_DRIVE  = 8'h04;
   localparam logic [7:0] SEL_WAKE_SOURCE = 8'h05;

   // Values after reset
   localparam logic [7:0] RST_SELECT      = 8'h00;
   localparam logic [7:0] RST_DIRECTION   = 8'hff;
   localparam logic [7:0] RST_PERIPHERAL  = 8'h00;
   localparam logic [7:0] RST_OPEN_DRAIN  = 8'h00;
   localparam logic [7:0] RST_HIGH_DRIVE  = 8'h00;
   localparam logic [7:0] RST_WAKE_SOURCE = 8'h00;
   localparam logic [7:0] RST_OUTPUT      = 8'h00;
   localparam logic [7:0] RST_SAMPLE      = 8'h00;

   // Synchroniser depth on the pin inputs
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              we;
      logic              re;
   } gpc_req_t;

   typedef struct packed {
      logic [PORT_W-1:0] level;
      logic [PORT_W-1:0] enable;
   } gpc_drive_t;

   typedef struct packed {
      logic [7:0]        subreg_select;
      logic [PORT_W-1:0] direction_bits;
      logic [PORT_W-1:0] peripheral_function_bits;
      logic [PORT_W-1:0] open_drain_bits;
      logic [PORT_W-1:0] high_current_bits;
      logic [PORT_W-1:0] wake_source_bits;
      logic [PORT_W-1:0] pin_drive_bits;
      logic [PORT_W-1:0] port_input_sample;
      logic [PORT_W-1:0] input_prev;
      logic [7:0]        read_data;
      logic [PORT_W-1:0] pin_level;
      logic [PORT_W-1:0] pin_enable;
      logic [PORT_W-1:0] pin_high;
      logic              stop_recover;
   } gpc_state_t;

endpackage

// *** gpc_sync.sv ***
/*
 Multi-bit two-stage synchroniser for the port pins.
 Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/100ps
module gpc_sync
   import gpc_pkg::*;
#(
   parameter int WIDTH = PORT_W
) (
   input  wire logic             clock,   // System clock
   input  wire logic             rst_n,   // Async reset, active low
   input  wire logic [WIDTH-1:0] d_async, // Pin levels
   output logic      [WIDTH-1:0] q_sync   // Synchronised levels
);

   logic [WIDTH-1:0] stage1_reg;

   // First stage feeds only the second one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         q_sync     <= '0;
      end else begin
         stage1_reg <= d_async;
         q_sync     <= stage1_reg;
      end
   end

endmodule

// *** gpc_port.sv ***
/*
 Eight-bit general-purpose port control: select and window registers,
 per-pin direction, peripheral hand-over, open-drain, high drive and
 stop-mode wake sources, plus input and output data registers.
 Assumes a same-clock register master and same-clock peripherals and
 power controller; only the pins are asynchronous.
*/
// Local design decision: the plain strobed port.
// Function
// - Select code 03H makes the window reach the open-drain bits.
// - An open-drain bit of 1 removes the high half of its pin's drive.
// - Open-drain acts even while a peripheral owns the pin.
// - Select code 04H makes the window reach the high-current bits.
// - A high-current bit of 1 asks for strong drive, 0 for standard.
// - High-current selection acts even while a peripheral owns the pin.
// - Select code 05H makes the window reach the wake-source bits.
// - In stop mode any change on an enabled pin starts recovery.
// - The input register is read-only and returns sampled pin levels.
// - Output data drive a pin only if it is an output and not handed over.
// - An output bit of 1 is never driven high when open-drain is set.
// - Codes 01H and 02H reach direction and peripheral bits; codes outside 01H-05H reach none.
// - Direction 0 drives the output data, 1 makes the pin an input.
// - A peripheral bit of 1 hands the pin over and overrides direction.
`timescale 1ns/100ps
module gpc_port
   import gpc_pkg::*;
(
   input  wire logic              clock,          // 250 MHz system clock
   input  wire logic              rst_n,          // Async reset, active low
   input  wire gpc_req_t          reg_req,        // Register request
   output logic      [7:0]        reg_rdata,      // Read data, next cycle
   input  wire logic [PORT_W-1:0] pin_in,         // Pin levels, async
   output logic      [PORT_W-1:0] pin_out,        // Pin output level
   output logic      [PORT_W-1:0] pin_oe,         // Pin output enable
   output logic      [PORT_W-1:0] pin_high_drive, // Strong drive select
   input  wire gpc_drive_t        periph_drive,   // Peripheral pin drive
   output logic      [PORT_W-1:0] pin_sample,     // Synchronised pins
   input  wire logic              stop_mode,      // Device is in stop mode
   output logic                   stop_recover    // Recovery request pulse
);

   gpc_state_t        st_reg;
   gpc_state_t        st_next;
   logic [PORT_W-1:0] pin_sync;
   logic [PORT_W-1:0] pin_value;
   logic [PORT_W-1:0] pin_enable;
   logic [PORT_W-1:0] pin_changed;
   logic              win_hit;
   logic              win_valid;

   gpc_sync #(
      .WIDTH (PORT_W)
   ) u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .d_async (pin_in),
      .q_sync  (pin_sync)
   );

   assign win_hit   = reg_req.addr == OFF_SUBREG_WINDOW;
   assign win_valid = st_reg.subreg_select inside {SEL_DIRECTION,
      SEL_PERIPHERAL, SEL_OPEN_DRAIN, SEL_HIGH_DRIVE, SEL_WAKE_SOURCE};

   always_comb begin
      st_next              = st_reg;
      st_next.read_data    = 8'h00;
      st_next.stop_recover = 1'b0;
      // Sampled every cycle, whatever the pin direction
      st_next.port_input_sample = pin_sync;
      st_next.input_prev        = pin_sync;

      if (reg_req.we) begin
         if (reg_req.addr == OFF_SUBREG_SELECT) begin
            st_next.subreg_select = reg_req.wdata;
         end else if (win_hit) begin
            case (st_reg.subreg_select)
               SEL_DIRECTION: begin
                  st_next.direction_bits = reg_req.wdata;
               end
               SEL_PERIPHERAL: begin
                  st_next.peripheral_function_bits = reg_req.wdata;
               end
               SEL_OPEN_DRAIN: begin
                  st_next.open_drain_bits = reg_req.wdata;
               end
               SEL_HIGH_DRIVE: begin
                  st_next.high_current_bits = reg_req.wdata;
               end
               SEL_WAKE_SOURCE: begin
                  st_next.wake_source_bits = reg_req.wdata;
               end
               // Guard code: a stray window write changes nothing
               default: begin
               end
            endcase
         end else if (reg_req.addr == OFF_OUTPUT_VALUE) begin
            st_next.pin_drive_bits = reg_req.wdata;
         end
         // The input register ignores writes
      end

      if (reg_req.re) begin
         if (reg_req.addr == OFF_SUBREG_SELECT) begin
            st_next.read_data = st_reg.subreg_select;
         end else if (win_hit) begin
            case (st_reg.subreg_select)
               SEL_DIRECTION: begin
                  st_next.read_data = st_reg.direction_bits;
               end
               SEL_PERIPHERAL: begin
                  st_next.read_data = st_reg.peripheral_function_bits;
               end
               SEL_OPEN_DRAIN: begin
                  st_next.read_data = st_reg.open_drain_bits;
               end
               SEL_HIGH_DRIVE: begin
                  st_next.read_data = st_reg.high_current_bits;
               end
               SEL_WAKE_SOURCE: begin
                  st_next.read_data = st_reg.wake_source_bits;
               end
               default: begin
                  st_next.read_data = 8'h00;
               end
            endcase
         end else if (reg_req.addr == OFF_INPUT_SAMPLE) begin
            st_next.read_data = st_reg.port_input_sample;
         end else if (reg_req.addr == OFF_OUTPUT_VALUE) begin
            st_next.read_data = st_reg.pin_drive_bits;
         end
      end

      // Any edge on an armed pin while stopped asks for recovery
      if (stop_mode && (pin_changed != '0)) begin
         st_next.stop_recover = 1'b1;
      end

      st_next.pin_level  = pin_value;
      st_next.pin_enable = pin_enable;
      // Strength follows the pin whoever drives it
      st_next.pin_high   = st_reg.high_current_bits;
   end

   // Compare two synchronised samples; never the raw pin
   assign pin_changed = (pin_sync ^ st_reg.input_prev)
                        & st_reg.wake_source_bits;

   // Peripheral bit picks the source of level and enable
   assign pin_value = (st_reg.peripheral_function_bits
                       & periph_drive.level)
                    | (~st_reg.peripheral_function_bits
                       & st_reg.pin_drive_bits);

   // Open-drain masks the high half after the source mux, so it also
   // holds for peripheral drive
   assign pin_enable = ((st_reg.peripheral_function_bits
                         & periph_drive.enable)
                      | (~st_reg.peripheral_function_bits
                         & ~st_reg.direction_bits))
                     & ~(st_reg.open_drain_bits & pin_value);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.subreg_select            <= RST_SELECT;
         st_reg.direction_bits           <= RST_DIRECTION;
         st_reg.peripheral_function_bits <= RST_PERIPHERAL;
         st_reg.open_drain_bits          <= RST_OPEN_DRAIN;
         st_reg.high_current_bits        <= RST_HIGH_DRIVE;
         st_reg.wake_source_bits         <= RST_WAKE_SOURCE;
         st_reg.pin_drive_bits           <= RST_OUTPUT;
         st_reg.port_input_sample        <= RST_SAMPLE;
         st_reg.input_prev               <= RST_SAMPLE;
         st_reg.read_data                <= 8'h00;
         st_reg.pin_level                <= RST_OUTPUT;
         st_reg.pin_enable               <= '0;
         st_reg.pin_high                 <= RST_HIGH_DRIVE;
         st_reg.stop_recover             <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata      = st_reg.read_data;
   assign pin_out        = st_reg.pin_level;
   assign pin_oe         = st_reg.pin_enable;
   assign pin_high_drive = st_reg.pin_high;
   assign pin_sample     = st_reg.port_input_sample;
   assign stop_recover   = st_reg.stop_recover;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_win_write(logic [7:0] code);
      reg_req.we && win_hit && st_reg.subreg_select == code;
   endsequence

   sequence s_win_read(logic [7:0] code);
      reg_req.re && win_hit && st_reg.subreg_select == code;
   endsequence

   property p_od_write;
      s_win_write(SEL_OPEN_DRAIN) |=>
         st_reg.open_drain_bits == $past(reg_req.wdata);
   endproperty
   a_od_write: assert property (p_od_write)
      else $error("Open-drain bits not written through window");

   property p_od_read;
      s_win_read(SEL_OPEN_DRAIN) |=>
         reg_rdata == $past(st_reg.open_drain_bits);
   endproperty
   a_od_read: assert property (p_od_read)
      else $error("Open-drain bits not read through window");

   property p_no_high_when_od;
      ##1 (pin_oe & pin_out & $past(st_reg.open_drain_bits)) == '0;
   endproperty
   a_no_high_when_od: assert property (p_no_high_when_od)
      else $error("Open-drain pin driven high");

   property p_od_low_driven;
      ##1 ((~$past(st_reg.open_drain_bits) | ~pin_out)
           & $past(~st_reg.peripheral_function_bits
                   & ~st_reg.direction_bits) & ~pin_oe) == '0;
   endproperty
   a_od_low_driven: assert property (p_od_low_driven)
      else $error("Output pin lost its drive");

   property p_od_periph;
      ##1 (pin_oe & pin_out & $past(st_reg.peripheral_function_bits
                                    & st_reg.open_drain_bits)) == '0;
   endproperty
   a_od_periph: assert property (p_od_periph)
      else $error("Open-drain ignored under peripheral drive");

   property p_hd_write;
      s_win_write(SEL_HIGH_DRIVE) |=>
         st_reg.high_current_bits == $past(reg_req.wdata)
         ##1 pin_high_drive == $past(reg_req.wdata, 2);
   endproperty
   a_hd_write: assert property (p_hd_write)
      else $error("High drive write did not reach the pins");

   property p_hd_follow;
      ##1 pin_high_drive == $past(st_reg.high_current_bits);
   endproperty
   a_hd_follow: assert property (p_hd_follow)
      else $error("High drive pin select wrong");

   property p_wake_write;
      s_win_write(SEL_WAKE_SOURCE) |=>
         st_reg.wake_source_bits == $past(reg_req.wdata);
   endproperty
   a_wake_write: assert property (p_wake_write)
      else $error("Wake source bits not written through window");

   property p_wake_fire;
      stop_mode && pin_changed != '0 |=> stop_recover;
   endproperty
   a_wake_fire: assert property (p_wake_fire)
      else $error("Armed pin change missed in stop mode");

   property p_wake_quiet;
      !(stop_mode && pin_changed != '0) |=> !stop_recover;
   endproperty
   a_wake_quiet: assert property (p_wake_quiet)
      else $error("Recovery raised without armed change");

   property p_in_read;
      reg_req.re && reg_req.addr == OFF_INPUT_SAMPLE |=>
         reg_rdata == $past(pin_sample);
   endproperty
   a_in_read: assert property (p_in_read)
      else $error("Input register read wrong value");

   property p_in_sync;
      $stable(pin_in)[*3] ##0 $past(rst_n, 4) |-> pin_sample == pin_in;
   endproperty
   a_in_sync: assert property (p_in_sync)
      else $error("Input sample does not follow steady pins");

   property p_gpio_drive;
      ##1 (($past(~st_reg.peripheral_function_bits
                  & ~st_reg.direction_bits))
           & (pin_out ^ $past(st_reg.pin_drive_bits))) == '0;
   endproperty
   a_gpio_drive: assert property (p_gpio_drive)
      else $error("Output pin level differs from output data");

   property p_input_tristate;
      ##1 (pin_oe & $past(~st_reg.peripheral_function_bits
                          & st_reg.direction_bits)) == '0;
   endproperty
   a_input_tristate: assert property (p_input_tristate)
      else $error("Input pin is driven");

   property p_periph_level;
      ##1 (($past(st_reg.peripheral_function_bits))
           & (pin_out ^ $past(periph_drive.level))) == '0;
   endproperty
   a_periph_level: assert property (p_periph_level)
      else $error("Handed-over pin not following peripheral");

   // Select must be rewritten between the two, so check each alone
   property p_dir_write;
      s_win_write(SEL_DIRECTION) |=>
         st_reg.direction_bits == $past(reg_req.wdata);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("Direction bits not written through window");

   property p_pf_write;
      s_win_write(SEL_PERIPHERAL) |=>
         st_reg.peripheral_function_bits == $past(reg_req.wdata);
   endproperty
   a_pf_write: assert property (p_pf_write)
      else $error("Peripheral bits not written through window");

   property p_guard_write;
      reg_req.we && win_hit && !win_valid |=>
         $stable(st_reg.direction_bits)
         && $stable(st_reg.peripheral_function_bits)
         && $stable(st_reg.open_drain_bits)
         && $stable(st_reg.high_current_bits)
         && $stable(st_reg.wake_source_bits);
   endproperty
   a_guard_write: assert property (p_guard_write)
      else $error("Window write under unused code changed state");

   property p_guard_read;
      reg_req.re && win_hit && !win_valid |=> reg_rdata == 8'h00;
   endproperty
   a_guard_read: assert property (p_guard_read)
      else $error("Window read under unused code not zero");

endmodule

// *** gpc_board.sv ***
/*
 Board model for the eight port pins: resolves each wire from the
 port's driver, an optional external driver and a pull-up resistor.
 Assumes the external driver is steered by the testbench.
*/
`timescale 1ns/100ps
module gpc_board
   import gpc_pkg::*;
(
   input  wire logic [PORT_W-1:0] pin_out,   // Port output level
   input  wire logic [PORT_W-1:0] pin_oe,    // Port output enable
   input  wire logic [PORT_W-1:0] ext_level, // External source level
   input  wire logic [PORT_W-1:0] ext_en,    // External source enable
   output logic      [PORT_W-1:0] pin_in     // Resolved wire level
);
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         // Two drivers in a fight leave the wire unknown
         if (pin_oe[i] && ext_en[i])
            pin_in[i] = (pin_out[i] == ext_level[i]) ? pin_out[i] : 1'bx;
         else if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_level[i];
         else
            pin_in[i] = 1'b1; // Pull-up holds a released pin high
      end
   end
endmodule

// *** testbench.sv ***
/*
 Self-checking testbench for the port control block: register tasks,
 pin drive, input sampling and stop-mode wake checks.
 Assumes the board model resolves the pins with a pull-up.
*/
`timescale 1ns/100ps
module testbench;
   import gpc_pkg::*;
   logic              clock;
   logic              rst_n;
   gpc_req_t          req;
   logic [7:0]        rdata;
   logic [PORT_W-1:0] pin_in, pin_out, pin_oe, pin_hd, pin_sample;
   logic [PORT_W-1:0] ext_level, ext_en;
   gpc_drive_t        periph;
   logic              stop_mode, stop_recover;
   int                num_errors, n_compared, cycles, n_rec;
   logic [7:0]        rst_tab [1:5];
   logic [7:0]        unused_codes [3];

   gpc_port i_dut (
      .clock          (clock),
      .rst_n          (rst_n),
      .reg_req        (req),
      .reg_rdata      (rdata),
      .pin_in         (pin_in),
      .pin_out        (pin_out),
      .pin_oe         (pin_oe),
      .pin_high_drive (pin_hd),
      .periph_drive   (periph),
      .pin_sample     (pin_sample),
      .stop_mode      (stop_mode),
      .stop_recover   (stop_recover)
   );

   gpc_board i_board (
      .pin_out   (pin_out),
      .pin_oe    (pin_oe),
      .ext_level (ext_level),
      .ext_en    (ext_en),
      .pin_in    (pin_in)
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Counts every cycle of the pulse, so a long pulse shows up
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (stop_recover === 1'b1)
         n_rec <= n_rec + 1;
      if (cycles == 6000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
      @(posedge clock);
      req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clock);
      req.we <= 1'b0;
   endtask

   task automatic rd(logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clock);
      req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clock);
      req.re <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic setw(logic [7:0] code, logic [7:0] d);
      wr(OFF_SUBREG_SELECT, code);
      wr(OFF_SUBREG_WINDOW, d);
   endtask

   task automatic getw(logic [7:0] code, output logic [7:0] d);
      wr(OFF_SUBREG_SELECT, code);
      rd(OFF_SUBREG_WINDOW, d);
   endtask

   task automatic settle(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   initial begin
      logic [7:0] v;
      rst_tab = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
      unused_codes = '{8'h00, 8'h06, 8'hff};
      rst_n = 1'b0;
      req = '0;
      periph = '0;
      stop_mode = 1'b0;
      ext_level = 8'h00;
      ext_en = 8'h00;
      num_errors = 0;
      n_compared = 0;
      cycles = 0;
      n_rec = 0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values, then every select code reaches its own bits
      rd(OFF_SUBREG_SELECT, v); check("select reset", v, 8'h00);
      rd(OFF_OUTPUT_VALUE, v); check("output reset", v, 8'h00);
      check("oe reset", pin_oe, 8'h00);
      for (int c = 1; c <= 5; c++) begin
         getw(c[7:0], v);
         check("window reset", v, rst_tab[c]);
         setw(c[7:0], 8'h5a ^ c[7:0]);
      end
      for (int c = 1; c <= 5; c++) begin
         getw(c[7:0], v);
         check("window rw", v, 8'h5a ^ c[7:0]);
      end
      // Unused codes leave everything alone and read zero
      foreach (unused_codes[k]) begin
         setw(unused_codes[k], 8'hc3);
         rd(OFF_SUBREG_SELECT, v); check("select rw", v, unused_codes[k]);
         rd(OFF_SUBREG_WINDOW, v);
         check("unused code", v, 8'h00);
      end
      getw(SEL_DIRECTION, v); check("dir kept", v, 8'h5b);
      wr(12'h0fd4, 8'h77);
      rd(12'h0fd4, v); check("unmapped", v, 8'h00);
      // Inputs: all pins in, board drives a pattern
      setw(SEL_DIRECTION, 8'hff);
      setw(SEL_PERIPHERAL, 8'h00);
      setw(SEL_OPEN_DRAIN, 8'h00);
      setw(SEL_WAKE_SOURCE, 8'h00);
      @(posedge clock);
      ext_en <= 8'hff;
      ext_level <= 8'h96;
      settle(5);
      check("oe inputs", pin_oe, 8'h00);
      check("sample", pin_sample, 8'h96);
      wr(OFF_INPUT_SAMPLE, 8'h00);
      rd(OFF_INPUT_SAMPLE, v); check("input reg", v, 8'h96);
      // Wake: only pin 0 armed, only while stopped
      setw(SEL_WAKE_SOURCE, 8'h01);
      n_rec <= 0;
      stop_mode <= 1'b1;
      settle(2);
      ext_level <= 8'h97;
      settle(8);
      check("wake rise", n_rec[7:0], 8'h01);
      ext_level <= 8'h95;
      settle(8);
      check("wake unarmed", n_rec[7:0], 8'h01);
      stop_mode <= 1'b0;
      ext_level <= 8'h94;
      settle(8);
      check("wake running", n_rec[7:0], 8'h01);
      stop_mode <= 1'b1;
      ext_level <= 8'h95;
      settle(8);
      check("wake again", n_rec[7:0], 8'h02);
      stop_mode <= 1'b0;
      // Outputs, open-drain and high drive
      ext_en <= 8'h00;
      wr(OFF_OUTPUT_VALUE, 8'ha5);
      rd(OFF_OUTPUT_VALUE, v); check("output rw", v, 8'ha5);
      setw(SEL_DIRECTION, 8'h00);
      setw(SEL_HIGH_DRIVE, 8'h3c);
      settle(2);
      check("oe out", pin_oe, 8'hff);
      check("out", pin_out, 8'ha5);
      check("high drive", pin_hd, 8'h3c);
      setw(SEL_OPEN_DRAIN, 8'h0f);
      settle(2);
      check("oe od", pin_oe, 8'hfa);
      check("pins od", pin_sample, 8'ha5);
      // Peripheral owns pins 0..3, pin 1 direction set to input;
      // its level differs from the output data so the source shows
      periph <= '{level: 8'hfa, enable: 8'h0e};
      setw(SEL_DIRECTION, 8'h02);
      setw(SEL_PERIPHERAL, 8'h0f);
      settle(2);
      check("oe periph", pin_oe, 8'hf4);
      check("out periph", pin_out, 8'haa);
      check("hd periph", pin_hd, 8'h3c);
      setw(SEL_OPEN_DRAIN, 8'h00);
      settle(2);
      check("oe no od", pin_oe, 8'hfe);
      print_verdict();
   end
endmodule
